// ---- bench/imsf_bus_model.sv ----
`default_nettype none
module imsf_bus_model (
   output logic SCL,
   output logic SDA
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pull-ups hold both lines high whenever no party drives them.
   initial begin
      SCL = 1'b1;
      SDA = 1'b1;
   end
   // start: data falls while the clock is high.
   task automatic start_c();
      SDA = 1'b0;
      #200;
      SCL = 1'b0;
      #200;
   endtask : start_c
   // stop: data rises while the clock is high.
   task automatic stop_c();
      SCL = 1'b1;
      #200;
      SDA = 1'b1;
      #200;
   endtask : stop_c
endmodule : imsf_bus_model
`default_nettype wire

// ---- bench/imsf_status_tb_top.sv ----
`default_nettype none
module imsf_status_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk;
   logic        rst;
   logic        scl;
   logic        sda;
   logic [15:0] ctl;
   logic        rd_en;
   logic [6:0]  ev;
   logic [1:0]  tx_cnt;
   logic [15:0] status;
   logic        irq;
   int          err_count;
   int          n_checks;
   int          cyc;
   logic [6:0]  evs  [6] = '{7'h41, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10};
   logic [15:0] exps [6] = '{16'h0208, 16'h0008, 16'h0100, 16'h0080, 16'h0010, 16'h0020};
   logic [15:0] ens  [6] = '{16'h0010, 16'h0010, 16'h0100, 16'h0080, 16'h0080, 16'h0040};
   imsf_bus_model bus (.SCL(scl), .SDA(sda));
   imsf_status DUT (
      .CLOCK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .MASTER_BUS_CONTROL(ctl),
      .STATUS_READ(rd_en), .RX_PUSH(ev[0]), .RX_FULL(ev[6]), .TX_FIFO_COUNT(tx_cnt),
      .ADDR_WRITE_SENT(ev[5]), .XFER_DONE(ev[1]), .DATA_NACK(ev[2]), .ADDR_NACK(ev[3]),
      .ARB_LOST(ev[4]), .MASTER_ACTIVE(ev[6] === 1'b0 && ctl[0]), .MASTER_BUS_STATUS(status),
      .IRQ(irq));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic pulse(input logic [6:0] v);
      ev = v;
      @(negedge clk);
      ev = 7'h00;
   endtask : pulse
   // A read returns the current value, then clears the sticky flags.
   task automatic rd(input logic [15:0] exp);
      chk(status, exp);
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
   endtask : rd
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      {ctl, rd_en, ev, tx_cnt, err_count, n_checks, cyc} = '0;
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(status, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      bus.start_c();
      repeat (10) @(negedge clk);
      chk(status, 16'h0400);
      bus.stop_c();
      repeat (10) @(negedge clk);
      chk(status, 16'h0000);
      $display("test bus condition done");
      for (int i = 0; i < 6; i++) begin
         // Only the other sources enabled: no interrupt may follow.
         ctl = 16'h01F0 ^ ens[i];
         pulse(evs[i]);
         chk({15'h0, irq}, 16'h0000);
         rd(exps[i]);
         chk(status, 16'h0000);
         ctl = ens[i];
         pulse(evs[i]);
         chk({15'h0, irq}, 16'h0001);
         rd(exps[i]);
         chk({15'h0, irq}, 16'h0000);
      end
      $display("test sticky flags done");
      ctl = 16'h0001;
      @(negedge clk);
      chk(status, 16'h0040);
      pulse(7'h10);
      rd(16'h0020);
      chk(status, 16'h0040);
      ctl = 16'h0020;
      @(negedge clk);
      $display("test master active done");
      pulse(7'h20);
      for (int c = 0; c < 4; c++) begin
         tx_cnt = c[1:0];
         @(negedge clk);
         rd({13'h0, (c < 2), c[1:0]});
         chk(status, {13'h0, (c < 2), c[1:0]});
         chk({15'h0, irq}, {15'h0, (c < 2)});
      end
      tx_cnt = 2'h0;
      pulse(7'h02);
      rd(16'h0100);
      $display("test transmit request done");
      // A refused data byte in the read cycle must survive that read.
      @(negedge clk);
      ev    = 7'h04;
      rd_en = 1'b1;
      @(negedge clk);
      {ev, rd_en} = '0;
      chk(status, 16'h0080);
      $display("test set wins done");
      finish_test();
   end
endmodule : imsf_status_tb_top
`default_nettype wire

// ---- core/imsf_bus_condition.sv ----
`default_nettype none
module imsf_bus_condition (
   input  wire logic CLOCK,
   input  wire logic RST,
   input  wire logic SCL_IN,
   input  wire logic SDA_IN,
   output logic      START_SEEN,
   output logic      STOP_SEEN
);
   typedef struct packed {
      logic [1:0][imsf_pkg::SYNC_STAGES-1:0] sync;
      logic [1:0]                            line;
      logic                                  start;
      logic                                  stop;
   } imsf_cond_s;

   imsf_cond_s state;
   imsf_cond_s next_state;
   logic [1:0] pin;

   assign pin = {SDA_IN, SCL_IN};

   // A line only changes once the second and third stages agree, which filters
   // single-cycle glitches at the cost of one extra cycle of latency.
   always_comb begin
      next_state       = state;
      next_state.start = 1'b0;
      next_state.stop  = 1'b0;
      for (int i = 0; i < 2; i++) begin
         next_state.sync[i] = {state.sync[i][1:0], pin[i]};
         if (state.sync[i][1] == state.sync[i][2]) begin
            next_state.line[i] = state.sync[i][2];
         end
      end
      if (state.line[0] && next_state.line[0]) begin
         next_state.start = state.line[1] && !next_state.line[1];
         next_state.stop  = !state.line[1] && next_state.line[1];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state <= '{sync: '1, line: 2'h3, start: 1'b0, stop: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign START_SEEN = state.start;
   assign STOP_SEEN  = state.stop;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   AST_NO_BOTH: assert property (!(START_SEEN && STOP_SEEN))
      else $error("Start and stop reported together.");
   AST_START_NEEDS_SCL: assert property (START_SEEN |-> state.line[0])
      else $error("Start reported while clock line low.");
endmodule : imsf_bus_condition
`default_nettype wire

// ---- core/imsf_status.sv ----
`default_nettype none
// Overview of operation
// - The bus activity flag sets on a start condition and clears on a stop from any master.
// - The receive overflow flag sets when a byte is pushed into an already full receive FIFO.
// - The transfer done flag sets when a transfer ends and interrupts if its enable is set.
// - The data no-acknowledge flag sets on a refused data byte and interrupts if enabled.
// - The master active flag is high while a transaction runs, low if idle or arbitration lost.
// - The arbitration lost flag sets when bus control is lost and interrupts if enabled.
// - The address no-acknowledge flag sets on a refused address and shares the nack enable.
// - The receive request flag sets when data enters the receive FIFO and interrupts if enabled.
// - After an address with write, the transmit request is high while the FIFO holds 0 or 1 byte.
// - The transmit FIFO level is reported on bits 1 to 0 as empty, one, two or full.
// - Bits 15 to 11 of the status register are reserved and read as zero.
// - The interrupt enables sit at bits 8 down to 4 of the master control register.
module imsf_status (
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   input  wire logic [15:0] MASTER_BUS_CONTROL,
   input  wire logic        STATUS_READ,
   input  wire logic        RX_PUSH,
   input  wire logic        RX_FULL,
   input  wire logic [1:0]  TX_FIFO_COUNT,
   input  wire logic        ADDR_WRITE_SENT,
   input  wire logic        XFER_DONE,
   input  wire logic        DATA_NACK,
   input  wire logic        ADDR_NACK,
   input  wire logic        ARB_LOST,
   input  wire logic        MASTER_ACTIVE,
   output logic [15:0]      MASTER_BUS_STATUS,
   output logic             IRQ
);
   typedef struct packed {
      logic [15:0] status;
      logic        write_phase;
      logic        irq;
   } imsf_state_s;

   imsf_state_s state;
   imsf_state_s next_state;
   logic        start_seen;
   logic        stop_seen;
   logic        rd;
   logic [15:0] st;
   logic [15:0] ns;
   logic [15:0] ctl;
   logic        next_tx_request;

   imsf_bus_condition u_bus_condition (
      .CLOCK      (CLOCK),
      .RST        (RST),
      .SCL_IN     (SCL_IN),
      .SDA_IN     (SDA_IN),
      .START_SEEN (start_seen),
      .STOP_SEEN  (stop_seen)
   );

   assign st  = state.status;
   assign ctl = MASTER_BUS_CONTROL;
   assign rd  = STATUS_READ;

   // Event flags are sticky until software reads the status register, so a
   // short event is never missed; an event in the read cycle wins over the clear.
   always_comb begin
      next_state  = state;
      ns          = st;
      if (start_seen) begin
         ns[imsf_pkg::BUS_ACTIVITY_BIT] = 1'b1;
      end else if (stop_seen) begin
         ns[imsf_pkg::BUS_ACTIVITY_BIT] = 1'b0;
      end
      ns[imsf_pkg::RX_OVERFLOW_BIT] = (RX_PUSH && RX_FULL)
                                      || (st[imsf_pkg::RX_OVERFLOW_BIT] && !rd);
      ns[imsf_pkg::TRANSFER_DONE_BIT] = XFER_DONE
                                        || (st[imsf_pkg::TRANSFER_DONE_BIT] && !rd);
      ns[imsf_pkg::DATA_NACK_BIT] = DATA_NACK || (st[imsf_pkg::DATA_NACK_BIT] && !rd);
      ns[imsf_pkg::ARB_LOST_BIT] = ARB_LOST || (st[imsf_pkg::ARB_LOST_BIT] && !rd);
      ns[imsf_pkg::MASTER_ACTIVE_BIT] = MASTER_ACTIVE && !ARB_LOST
                                        && !ns[imsf_pkg::ARB_LOST_BIT];
      ns[imsf_pkg::ADDR_NACK_BIT] = ADDR_NACK || (st[imsf_pkg::ADDR_NACK_BIT] && !rd);
      ns[imsf_pkg::RX_REQUEST_BIT] = RX_PUSH || (st[imsf_pkg::RX_REQUEST_BIT] && !rd);
      if (ADDR_WRITE_SENT) begin
         next_state.write_phase = 1'b1;
      end else if (XFER_DONE || ARB_LOST || ADDR_NACK) begin
         next_state.write_phase = 1'b0;
      end
      next_tx_request = next_state.write_phase
                        && (TX_FIFO_COUNT == imsf_pkg::TX_LEVEL_EMPTY
                            || TX_FIFO_COUNT == imsf_pkg::TX_LEVEL_ONE);
      ns[imsf_pkg::TX_REQUEST_BIT] = next_tx_request;
      ns[imsf_pkg::TX_LEVEL_LSB +: imsf_pkg::TX_LEVEL_WIDTH] = TX_FIFO_COUNT;
      ns[imsf_pkg::RESERVED_LSB +: imsf_pkg::RESERVED_WIDTH] = '0;
      next_state.status = ns;
      next_state.irq =
         (ns[imsf_pkg::TRANSFER_DONE_BIT] && ctl[imsf_pkg::DONE_IRQ_ENABLE_BIT])
         || ((ns[imsf_pkg::DATA_NACK_BIT] || ns[imsf_pkg::ADDR_NACK_BIT])
             && ctl[imsf_pkg::NACK_IRQ_ENABLE_BIT])
         || (ns[imsf_pkg::ARB_LOST_BIT] && ctl[imsf_pkg::ARB_IRQ_ENABLE_BIT])
         || (ns[imsf_pkg::TX_REQUEST_BIT] && ctl[imsf_pkg::TX_IRQ_ENABLE_BIT])
         || (ns[imsf_pkg::RX_REQUEST_BIT] && ctl[imsf_pkg::RX_IRQ_ENABLE_BIT]);
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state <= '{status: imsf_pkg::STATUS_RESET, write_phase: 1'b0, irq: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign MASTER_BUS_STATUS = state.status;
   assign IRQ               = state.irq;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   AST_BUS_SET: assert property (start_seen |=> MASTER_BUS_STATUS[10])
      else $error("Bus activity not set after start.");
   AST_BUS_CLR: assert property (stop_seen |=> !MASTER_BUS_STATUS[10])
      else $error("Bus activity not cleared after stop.");
   AST_BUS_HOLD: assert property ((!start_seen && !stop_seen)
      |=> $stable(MASTER_BUS_STATUS[10]))
      else $error("Bus activity changed without a bus condition.");
   AST_OVERFLOW: assert property ((RX_PUSH && RX_FULL) |=> MASTER_BUS_STATUS[9])
      else $error("Overflow not flagged.");
   AST_NO_FALSE_OVF: assert property ((!MASTER_BUS_STATUS[9] && !RX_FULL)
      |=> !MASTER_BUS_STATUS[9])
      else $error("Overflow flagged without a full push.");
   AST_OVF_CLEAR: assert property ((STATUS_READ && !(RX_PUSH && RX_FULL))
      |=> !MASTER_BUS_STATUS[9])
      else $error("Overflow flag survived a read.");
   AST_DONE_IRQ: assert property ((XFER_DONE && MASTER_BUS_CONTROL[8])
      |=> MASTER_BUS_STATUS[8] && IRQ)
      else $error("Completion flag or interrupt missing.");
   AST_DONE_CLEAR: assert property ((STATUS_READ && !XFER_DONE)
      |=> !MASTER_BUS_STATUS[8])
      else $error("Completion flag survived a read.");
   AST_DATA_NACK: assert property (DATA_NACK |=> MASTER_BUS_STATUS[7])
      else $error("Data nack not flagged.");
   AST_DATA_NACK_IRQ: assert property ((DATA_NACK && MASTER_BUS_CONTROL[7])
      |=> IRQ)
      else $error("Data nack interrupt missing.");
   AST_DATA_NACK_CLEAR: assert property ((STATUS_READ && !DATA_NACK)
      |=> !MASTER_BUS_STATUS[7])
      else $error("Data nack flag survived a read.");
   AST_BUSY_LOW: assert property ((!MASTER_ACTIVE || ARB_LOST)
      |=> !MASTER_BUS_STATUS[6])
      else $error("Master active while idle or after arbitration loss.");
   AST_BUSY_HIGH: assert property ((MASTER_ACTIVE && !ARB_LOST && !MASTER_BUS_STATUS[5])
      |=> MASTER_BUS_STATUS[6])
      else $error("Master active flag missing during a transaction.");
   AST_ARB: assert property (ARB_LOST |=> MASTER_BUS_STATUS[5])
      else $error("Arbitration loss not flagged.");
   AST_ARB_IRQ: assert property ((ARB_LOST && MASTER_BUS_CONTROL[6]) |=> IRQ)
      else $error("Arbitration interrupt missing.");
   AST_ARB_CLEAR: assert property ((STATUS_READ && !ARB_LOST)
      |=> !MASTER_BUS_STATUS[5])
      else $error("Arbitration flag survived a read.");
   AST_ADDR_NACK_IRQ: assert property ((ADDR_NACK && MASTER_BUS_CONTROL[7])
      |=> MASTER_BUS_STATUS[4] && IRQ)
      else $error("Address nack flag or interrupt missing.");
   AST_ADDR_NACK_CLEAR: assert property ((STATUS_READ && !ADDR_NACK)
      |=> !MASTER_BUS_STATUS[4])
      else $error("Address nack flag survived a read.");
   AST_RX_REQ: assert property (RX_PUSH |=> MASTER_BUS_STATUS[3])
      else $error("Receive request not set.");
   AST_RX_IRQ: assert property ((RX_PUSH && MASTER_BUS_CONTROL[4]) |=> IRQ)
      else $error("Receive interrupt missing.");
   AST_RX_CLEAR: assert property ((STATUS_READ && !RX_PUSH)
      |=> !MASTER_BUS_STATUS[3])
      else $error("Receive request survived a read.");
   AST_TX_REQ: assert property (MASTER_BUS_STATUS[2] |-> $past(TX_FIFO_COUNT) <= 2'h1)
      else $error("Transmit request with more than one byte queued.");
   AST_TX_REQ_SET: assert property ((ADDR_WRITE_SENT && TX_FIFO_COUNT == 2'h0)
      |=> MASTER_BUS_STATUS[2])
      else $error("Transmit request missing after address write.");
   AST_TX_IRQ: assert property ((MASTER_BUS_CONTROL[5] && ADDR_WRITE_SENT
      && TX_FIFO_COUNT == 2'h1) |=> MASTER_BUS_STATUS[2] && IRQ)
      else $error("Transmit request interrupt missing.");
   AST_TX_REQ_CLR: assert property ((XFER_DONE && !ADDR_WRITE_SENT)
      |=> !MASTER_BUS_STATUS[2])
      else $error("Transmit request after the transfer ended.");
   AST_TX_REQ_FULL: assert property (TX_FIFO_COUNT[1]
      |=> !MASTER_BUS_STATUS[2])
      else $error("Transmit request with two or more bytes queued.");
   AST_LEVEL: assert property (1'b1 |=> MASTER_BUS_STATUS[1:0] == $past(TX_FIFO_COUNT))
      else $error("Transmit level mismatch.");
   AST_RESERVED: assert property (MASTER_BUS_STATUS[15:11] == 5'h00)
      else $error("Reserved status bits nonzero.");
   AST_NO_IRQ: assert property ((MASTER_BUS_CONTROL[8:4] == 5'h00) |=> !IRQ)
      else $error("Interrupt with all enables clear.");
   AST_IRQ_SOURCE: assert property (IRQ |-> (MASTER_BUS_STATUS[8:7] != 2'h0
      || MASTER_BUS_STATUS[5:2] != 4'h0))
      else $error("Interrupt with no flag set.");
   AST_HOLD: assert property ((MASTER_BUS_STATUS[8] && !STATUS_READ)
      |=> MASTER_BUS_STATUS[8])
      else $error("Completion flag lost without a read.");
   AST_ARB_HOLD: assert property ((MASTER_BUS_STATUS[5] && !STATUS_READ)
      |=> MASTER_BUS_STATUS[5])
      else $error("Arbitration flag lost without a read.");
   AST_RX_HOLD: assert property ((MASTER_BUS_STATUS[3] && !STATUS_READ)
      |=> MASTER_BUS_STATUS[3])
      else $error("Receive request lost without a read.");

   COV_START: cover property (start_seen ##[1:1000] stop_seen);
   COV_OVF: cover property (RX_PUSH && RX_FULL);
   COV_TX: cover property (ADDR_WRITE_SENT ##1 MASTER_BUS_STATUS[2] ##[1:50] XFER_DONE);
   COV_SET_WINS: cover property (STATUS_READ && DATA_NACK);
   COV_ARB_BUSY: cover property (MASTER_ACTIVE ##1 ARB_LOST);
endmodule : imsf_status
`default_nettype wire

// ---- inc/imsf_pkg.sv ----
`default_nettype none
package imsf_pkg;
   // Status register field positions.
   localparam int unsigned BUS_ACTIVITY_BIT   = 10;
   localparam int unsigned RX_OVERFLOW_BIT    = 9;
   localparam int unsigned TRANSFER_DONE_BIT  = 8;
   localparam int unsigned DATA_NACK_BIT      = 7;
   localparam int unsigned MASTER_ACTIVE_BIT  = 6;
   localparam int unsigned ARB_LOST_BIT       = 5;
   localparam int unsigned ADDR_NACK_BIT      = 4;
   localparam int unsigned RX_REQUEST_BIT     = 3;
   localparam int unsigned TX_REQUEST_BIT     = 2;
   localparam int unsigned TX_LEVEL_LSB       = 0;
   localparam int unsigned TX_LEVEL_WIDTH     = 2;
   localparam int unsigned RESERVED_LSB       = 11;
   localparam int unsigned RESERVED_WIDTH     = 5;
   localparam int unsigned STATUS_WIDTH       = 16;
   // Control register interrupt enable positions.
   localparam int unsigned DONE_IRQ_ENABLE_BIT = 8;
   localparam int unsigned NACK_IRQ_ENABLE_BIT = 7;
   localparam int unsigned ARB_IRQ_ENABLE_BIT  = 6;
   localparam int unsigned TX_IRQ_ENABLE_BIT   = 5;
   localparam int unsigned RX_IRQ_ENABLE_BIT   = 4;
   // Reset value and transmit FIFO level codes.
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [1:0]  TX_LEVEL_EMPTY = 2'h0;
   localparam logic [1:0]  TX_LEVEL_ONE   = 2'h1;
   localparam logic [1:0]  TX_LEVEL_TWO   = 2'h2;
   localparam logic [1:0]  TX_LEVEL_FULL  = 2'h3;
   // Bus line synchroniser depth.
   localparam int unsigned SYNC_STAGES = 3;
endpackage : imsf_pkg
`default_nettype wire
